//--- rtl/pcr_pkg.sv
`default_nettype none

package pcr_pkg;

   // ----------------------------------------------------------------------
   // strap and ratio layout
   // ----------------------------------------------------------------------
   localparam int         STRAP_W      = 4;
   localparam int         RATIO_W      = 5;
   localparam int         SYNC_STAGES  = 2;
   localparam logic [4:0] RATIO_RESET  = 5'h00;
   localparam logic [3:0] STRAP_RESET  = 4'h0;

   // ratio values per strap code
   localparam logic [4:0] RATIO_16     = 5'h10;
   localparam logic [4:0] RATIO_2      = 5'h02;
   localparam logic [4:0] RATIO_3      = 5'h03;
   localparam logic [4:0] RATIO_4      = 5'h04;
   localparam logic [4:0] RATIO_5      = 5'h05;
   localparam logic [4:0] RATIO_6      = 5'h06;
   localparam logic [4:0] RATIO_8      = 5'h08;
   localparam logic [4:0] RATIO_9      = 5'h09;
   localparam logic [4:0] RATIO_10     = 5'h0a;
   localparam logic [4:0] RATIO_12     = 5'h0c;
   localparam logic [4:0] RATIO_20     = 5'h14;

   // settle count at capture (fourth edge after reset release): two sync stages must fill
   localparam logic [1:0] CAPTURE_WAIT = 2'h2;

   typedef enum logic [1:0]
   {
      PCR_IN_RESET = 2'b00,
      PCR_SETTLE   = 2'b01,
      PCR_LOCKED   = 2'b10
   } pcr_state_t;

endpackage : pcr_pkg

`default_nettype wire

//--- rtl/pcr_ratio_strap.sv
`timescale 1ns/100ps
`default_nettype none

module pcr_ratio_strap
   import pcr_pkg::*;
(
   input  wire logic               i_clk,
   input  wire logic               i_srst,
   input  wire logic [STRAP_W-1:0] i_ratio_strap_lines,
   output logic      [RATIO_W-1:0] o_platform_ratio,
   output logic      [RATIO_W-1:0] o_mem_bus_ratio2,
   output logic                    o_ratio_valid,
   output logic                    o_ratio_reserved,
   output logic                    o_ratio_locked
);

   // ----------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------
   // returns zero for reserved codes so that zero means "no ratio"
   function automatic logic [RATIO_W-1:0] pcr_decode(input logic [STRAP_W-1:0] code);
      logic [RATIO_W-1:0] r;
      r = RATIO_RESET;
      case (code)
         4'h0:    r = RATIO_16;
         4'h2:    r = RATIO_2;
         4'h3:    r = RATIO_3;
         4'h4:    r = RATIO_4;
         4'h5:    r = RATIO_5;
         4'h6:    r = RATIO_6;
         4'h8:    r = RATIO_8;
         4'h9:    r = RATIO_9;
         4'ha:    r = RATIO_10;
         4'hc:    r = RATIO_12;
         4'hd:    r = RATIO_20;
         default: r = RATIO_RESET;
      endcase
      return r;
   endfunction : pcr_decode

   // ----------------------------------------------------------------------
   // strap synchroniser
   // ----------------------------------------------------------------------
   logic [STRAP_W-1:0] sync1_reg;
   logic [STRAP_W-1:0] sync2_reg;

   // straps are board levels, so they pass two flops before use
   always_ff @(posedge i_clk)
   begin
      sync1_reg <= i_ratio_strap_lines;
      sync2_reg <= sync1_reg;
   end

   // ----------------------------------------------------------------------
   // capture sequencer
   // ----------------------------------------------------------------------
   pcr_state_t         state_reg;
   pcr_state_t         state_next;
   logic [1:0]         wait_reg;
   logic [RATIO_W-1:0] ratio_reg;
   logic               valid_reg;
   logic               resv_reg;
   logic               locked_reg;
   logic [RATIO_W-1:0] mem2_reg;

   // decode runs every cycle but is only looked at on the capture edge;
   // a reserved code decodes to zero, which doubles as the invalid marker
   // so that no separate reserved table has to be kept in step with it
   wire logic [RATIO_W-1:0] decoded_w  = pcr_decode(sync2_reg);
   wire logic               is_resv_w  = (decoded_w == RATIO_RESET);
   wire logic               capture_w  = (state_reg == PCR_SETTLE) && (wait_reg == CAPTURE_WAIT);

   // settle lets the synchroniser flush stale pre-release levels
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         PCR_IN_RESET: state_next = PCR_SETTLE;
         PCR_SETTLE:   state_next = capture_w ? PCR_LOCKED : PCR_SETTLE;
         PCR_LOCKED:   state_next = PCR_LOCKED;
         default:      state_next = PCR_IN_RESET;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         state_reg <= PCR_IN_RESET;
         wait_reg  <= 2'h0;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg == PCR_SETTLE && !capture_w)
            wait_reg <= wait_reg + 2'h1;
      end
   end

   // ratio held until the next reset; later strap changes are ignored
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         ratio_reg  <= RATIO_RESET;
         mem2_reg   <= RATIO_RESET;
         valid_reg  <= 1'b0;
         resv_reg   <= 1'b0;
         locked_reg <= 1'b0;
      end
      else if (capture_w)
      begin
         ratio_reg  <= decoded_w;
         mem2_reg   <= decoded_w;
         valid_reg  <= !is_resv_w;
         resv_reg   <= is_resv_w;
         locked_reg <= 1'b1;
      end
   end

   // memory bus ratio is expressed in half-steps: ref*mem2/2
   assign o_platform_ratio = ratio_reg;
   assign o_mem_bus_ratio2 = mem2_reg;
   assign o_ratio_valid    = valid_reg;
   assign o_ratio_reserved = resv_reg;
   assign o_ratio_locked   = locked_reg;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   // checks sample at the clock edge, so a capture on the fourth edge after
   // release shows up as lock at the fifth sampled edge
   sequence s_lock_rise;
      !o_ratio_locked ##1 o_ratio_locked;
   endsequence

   // first edge that sees reset low
   sequence s_release;
      $fell(i_srst);
   endsequence

   // the settle edges, with no lock showing yet
   sequence s_settle_wait;
      !o_ratio_locked [*4];
   endsequence

   chk_ratio_hold: assert property (@(posedge i_clk) disable iff (i_srst)
      o_ratio_locked |=> $stable(o_platform_ratio) && o_ratio_locked)
      else $error("ratio changed after lock");

   chk_lock_time: assert property (@(posedge i_clk)
      $fell(i_srst) |-> ##[3:5] o_ratio_locked)
      else $error("ratio not locked in time");

   chk_decode_val: assert property (@(posedge i_clk) disable iff (i_srst)
      s_lock_rise |-> o_platform_ratio == $past(decoded_w))
      else $error("ratio does not match strap");

   chk_resv_flag: assert property (@(posedge i_clk) disable iff (i_srst)
      o_ratio_locked |-> (o_ratio_reserved == (o_platform_ratio == RATIO_RESET))
                         && (o_ratio_valid != o_ratio_reserved))
      else $error("reserved flag wrong");

   chk_code_zero: assert property (@(posedge i_clk) disable iff (i_srst)
      s_lock_rise ##0 ($past(sync2_reg) == 4'h0) |-> o_platform_ratio == RATIO_16)
      else $error("code 0000 not sixteen");

   chk_code_d: assert property (@(posedge i_clk) disable iff (i_srst)
      s_lock_rise ##0 ($past(sync2_reg) == 4'hd) |-> o_platform_ratio == RATIO_20)
      else $error("code 1101 not twenty");

   chk_mem_half: assert property (@(posedge i_clk) disable iff (i_srst)
      o_mem_bus_ratio2 == o_platform_ratio)
      else $error("memory bus ratio not half platform");

   chk_reset_clr: assert property (@(posedge i_clk)
      i_srst |=> !o_ratio_locked && !o_ratio_valid && o_platform_ratio == RATIO_RESET)
      else $error("reset did not clear ratio");

   // lock must land on exactly one edge: early lock would read a stale strap
   chk_lock_exact: assert property (@(posedge i_clk)
      s_release |-> s_settle_wait ##1 o_ratio_locked)
      else $error("lock edge not where expected");

   // nothing may leak out before the capture edge
   chk_flags_clear: assert property (@(posedge i_clk) disable iff (i_srst)
      !o_ratio_locked |-> !o_ratio_valid && !o_ratio_reserved
                          && o_platform_ratio == RATIO_RESET
                          && o_mem_bus_ratio2 == RATIO_RESET)
      else $error("ratio visible before lock");

   chk_lock_state: assert property (@(posedge i_clk) disable iff (i_srst)
      o_ratio_locked == (state_reg == PCR_LOCKED))
      else $error("lock flag disagrees with sequencer");

   chk_state_legal: assert property (@(posedge i_clk) disable iff (i_srst)
      state_reg inside {PCR_IN_RESET, PCR_SETTLE, PCR_LOCKED})
      else $error("sequencer in unused state");

   // the settle counter must never run past the capture point
   chk_wait_bound: assert property (@(posedge i_clk) disable iff (i_srst)
      wait_reg <= CAPTURE_WAIT)
      else $error("settle count overran");

   chk_code_one: assert property (@(posedge i_clk) disable iff (i_srst)
      s_lock_rise ##0 ($past(sync2_reg) == 4'h1) |-> o_ratio_reserved && !o_ratio_valid)
      else $error("code 0001 not reserved");

   chk_code_b: assert property (@(posedge i_clk) disable iff (i_srst)
      s_lock_rise ##0 ($past(sync2_reg) == 4'hb) |-> o_ratio_reserved && !o_ratio_valid)
      else $error("code 1011 not reserved");

   chk_lock_flag: assert property (@(posedge i_clk) disable iff (i_srst)
      s_lock_rise |-> o_ratio_valid != o_ratio_reserved)
      else $error("lock without exactly one verdict");

endmodule : pcr_ratio_strap

`default_nettype wire

//--- tb/pcr_strap_board.sv
`timescale 1ns/100ps
`default_nettype none

// board pull resistors: every strap line held at a firm level, none left floating
module pcr_strap_board
   import pcr_pkg::*;
(
   input  wire logic [STRAP_W-1:0] i_code,
   output logic      [STRAP_W-1:0] o_ratio_strap_lines
);
   assign o_ratio_strap_lines = i_code;
endmodule : pcr_strap_board

`default_nettype wire

//--- tb/platform_clock_ratio_strap_test.sv
`timescale 1ns/100ps
`default_nettype none

module platform_clock_ratio_strap_test;
   import pcr_pkg::*;
   logic               i_clk;
   logic               i_srst;
   logic [STRAP_W-1:0] code;
   logic [STRAP_W-1:0] strap;
   logic [RATIO_W-1:0] ratio;
   logic [RATIO_W-1:0] mem2;
   logic               valid;
   logic               rsvd;
   logic               locked;
   int                 failures;
   int                 checked;
   int                 edges;
   // board clocking for the ratio scenario: reference clock in MHz, memory data rate in MT/s
   localparam int      REF_MHZ = 100;
   localparam int      DDR_MTS = 400;
   // expected ratio per strap code, zero where the code is reserved
   logic [4:0] tbl [16] = '{5'h10, 5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h00,
                            5'h08, 5'h09, 5'h0a, 5'h00, 5'h0c, 5'h14, 5'h00, 5'h00};

   pcr_strap_board board (.i_code(code), .o_ratio_strap_lines(strap));
   pcr_ratio_strap uut (.i_clk(i_clk), .i_srst(i_srst), .i_ratio_strap_lines(strap),
      .o_platform_ratio(ratio), .o_mem_bus_ratio2(mem2), .o_ratio_valid(valid),
      .o_ratio_reserved(rsvd), .o_ratio_locked(locked));

   initial
   begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic print_verdict;
      if (failures == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   // straps settle during reset and stay put; the wait for lock is bounded
   task automatic power_up(input logic [3:0] c);
      @(posedge i_clk);
      #1 i_srst = 1'b1;
      code = c;
      repeat (3) @(posedge i_clk);
      #1 check("locked_in_reset", {7'h0, locked}, 8'h00);
      i_srst = 1'b0;
      edges = 0;
      while (locked !== 1'b1 && edges < 10)
      begin
         @(posedge i_clk);
         #1 edges++;
      end
      if (locked !== 1'b1)
      begin
         failures++;
         print_verdict();
      end
      check("lock_edges", edges[7:0], 8'h04);
   endtask : power_up

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic sweep_codes;
      for (int c = 0; c < 16; c++)
      begin
         power_up(c[3:0]);
         check("ratio", {3'h0, ratio}, {3'h0, tbl[c]});
         check("mem_ratio", {3'h0, mem2}, {3'h0, tbl[c]});
         check("valid", {7'h0, valid}, {7'h0, tbl[c] != 5'h00});
         check("reserved", {7'h0, rsvd}, {7'h0, tbl[c] == 5'h00});
      end
   endtask : sweep_codes

   // a strap change after capture must leave the latched ratio alone
   task automatic strap_hold;
      power_up(4'h5);
      code = 4'hd;
      repeat (6) @(posedge i_clk);
      #1 check("held_ratio", {3'h0, ratio}, 8'h05);
      check("held_lock", {7'h0, locked}, 8'h01);
      check("held_valid", {7'h0, valid}, 8'h01);
   endtask : strap_hold

   // a legal board: strap picked so platform equals the memory data rate
   task automatic board_config;
      int plat_mhz;
      int mem_mhz;
      power_up(4'h4);
      plat_mhz = REF_MHZ * int'(ratio);
      mem_mhz = (REF_MHZ * int'(mem2)) / 2;
      check("platform_is_ddr", {7'h0, plat_mhz == DDR_MTS}, 8'h01);
      check("mem_half_ddr", {7'h0, (mem_mhz * 2) == DDR_MTS}, 8'h01);
      check("mem_in_grade", {7'h0, mem_mhz >= 166 && mem_mhz <= 200}, 8'h01);
   endtask : board_config

   initial
   begin
      i_srst = 1'b1;
      code = 4'h0;
      failures = 0;
      checked = 0;
      repeat (3) @(posedge i_clk);
      sweep_codes();
      strap_hold();
      board_config();
      print_verdict();
   end
endmodule : platform_clock_ratio_strap_test

`default_nettype wire
